// *** pkg/eeprom_config_map.svh ***
`ifndef EEPROM_CONFIG_MAP_SVH
`define EEPROM_CONFIG_MAP_SVH

// Word addresses in the configuration memory
`define W_COUNT 5'h00
`define W_FLAG 5'h01
`define W_MAC0 5'h04
`define W_MAC1 5'h05
`define W_MAC2 5'h06
`define W_SUM_FIRST 5'h07
`define W_SUM_LAST 5'h0E
`define W_PHYOFS 5'h0F
`define W_MAXPKT 5'h10
`define W_PHYID 5'h11
`define W_WATER 5'h12
`define W_LAST_PRELOAD 5'h14
`define W_CHECKSUM 5'h18
`define PRELOAD_WORDS 21
`define BLANK_WORD 16'hFFFF
`define SUM_BASE 8'hFF

// Flag word bit positions
`define F_SELF_PWR 0
`define F_REF_OUT 1
`define F_RWAKE 2
`define F_COPPER 5
`define F_STRIP 6
`define F_APPEND 7
`define F_CAPTURE 8
`define F_TEST 9
`define F_ISOLATE 11
`define F_WPIN 12
`define F_WPOL 13
`define F_WTYPE 14
`define F_WPULSE 15

// Phy kind codes
`define KIND_UNSUPPORTED 3'h7

// Management power-down write
`define MGMT_CTRL_REG 5'h00
`define MGMT_BROADCAST 5'h00
`define MGMT_PWR_DOWN 16'h0800
`define MGMT_LAST_IDX 2'h2

// Fallback image, words 00h..14h; station address left at zero
`define ROM_00 16'h0015
`define ROM_01 16'h1DFD
`define ROM_02 16'h1220
`define ROM_03 16'h2729
`define ROM_04 16'h0000
`define ROM_05 16'h0000
`define ROM_06 16'h0000
`define ROM_07 16'h0409
`define ROM_08 16'h2260
`define ROM_09 16'h1271
`define ROM_0A 16'h0E19
`define ROM_0B 16'h043D
`define ROM_0F 16'h0580
`define ROM_10 16'h0600
`define ROM_11 16'hE010
`define ROM_12 16'h2442
`define ROM_13 16'h1240
`define ROM_14 16'h2749

// Timing
`define CLK_PERIOD_NS 20
`define WAKE_PULSE_NS 1363000

// Register port byte offsets and bits
`define REG_STATUS 4'h0
`define REG_FLAG 4'h4
`define REG_CTRL 4'h8
`define CTRL_WAKE_CLR 0
`define CTRL_GPIO_VAL 1

`endif

// *** pkg/eeprom_config_pkg.sv ***
package eeprom_config_pkg;

    typedef enum logic [2:0] {
        LD_IDLE,
        LD_WAIT,
        LD_CHECK,
        LD_APPLY,
        LD_MGMT,
        LD_DONE
    } load_state_type;

    typedef struct packed {
        logic self_powered_flag;
        logic ref_clock_drive_out;
        logic remote_wake_capable;
        logic phy_copper_fiber_select;
        logic rx_strip_fcs;
        logic tx_append_fcs;
        logic capture_effect_enable;
        logic test_port_enable;
        logic rmii_isolate;
        logic wake_pin_select;
        logic wake_out_polarity;
        logic wake_out_drive_type;
        logic wake_out_pulse_mode;
        logic [47:0] station_address;
        logic [4:0] phy_reg_offset1;
        logic [4:0] phy_reg_offset2;
        logic [2:0] embedded_phy_link_mode;
        logic [10:0] max_frame_size;
        logic [2:0] primary_phy_kind_code;
        logic [4:0] primary_phy_mgmt_address;
        logic [2:0] secondary_phy_kind_code;
        logic [4:0] secondary_phy_mgmt_address;
        logic primary_phy_supported;
        logic secondary_phy_supported;
        logic [7:0] pause_high_mark;
        logic [7:0] pause_low_mark;
    } cfg_type;

    typedef struct packed {
        logic [4:0] phy_addr;
        logic [4:0] reg_addr;
        logic [15:0] data;
    } mgmt_req_type;

endpackage

// *** rtl/eeprom_config_preload.sv ***
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "eeprom_config_map.svh"

module eeprom_config_preload
    import eeprom_config_pkg::*;
#(
    parameter int WAKE_PULSE_CYCLES = `WAKE_PULSE_NS / `CLK_PERIOD_NS
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Configuration memory word port
    output logic mem_rd_r,
    output logic [4:0] mem_addr_r,
    input wire logic mem_valid,
    input wire logic [15:0] mem_data,
    // Operating mode inputs
    input wire logic mac_mode_ext_rmii,
    input wire logic phy_mode,
    input wire logic wol_ready_mode,
    input wire logic phy_reset_n,
    // Management write port
    output logic mgmt_req_r,
    output mgmt_req_type mgmt_cmd_r,
    input wire logic mgmt_ack,
    // Loaded configuration
    output logic config_done_r,
    output cfg_type cfg_r,
    output logic [2:0] embedded_phy_link_mode_r,
    // Flow control
    input wire logic [7:0] free_buffers,
    input wire logic full_duplex,
    output logic pause_active_r,
    output logic jam_active_r,
    // Pins
    input wire logic wake_event,
    output logic wake_pin_out_r,
    output logic wake_pin_oe_r,
    output logic rmii_rx_oe_r,
    output logic rmii_ref_oe_r,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_r
);

    localparam logic [16:0] PULSE_LEN = 17'(WAKE_PULSE_CYCLES);

    load_state_type state_r, state_nxt;
    logic [15:0] img_r [0:`PRELOAD_WORDS-1];
    logic img_we;
    logic [4:0] mem_addr_nxt;
    logic mem_rd_nxt;
    logic [7:0] sum_r, sum_nxt;
    logic [7:0] csum_r, csum_nxt;
    logic use_rom_r, use_rom_nxt;
    logic blank_r, blank_nxt;
    logic done_nxt;
    cfg_type cfg_nxt;
    logic [1:0] mgmt_idx_r, mgmt_idx_nxt;
    logic mgmt_req_nxt;
    mgmt_req_type mgmt_cmd_nxt;
    logic mgmt_done_r, mgmt_done_nxt;

    function automatic logic [15:0] rom_word(input logic [4:0] a);
        case (a)
            5'h00: rom_word = `ROM_00;
            5'h01: rom_word = `ROM_01;
            5'h02: rom_word = `ROM_02;
            5'h03: rom_word = `ROM_03;
            5'h04: rom_word = `ROM_04;
            5'h05: rom_word = `ROM_05;
            5'h06: rom_word = `ROM_06;
            5'h07: rom_word = `ROM_07;
            5'h08: rom_word = `ROM_08;
            5'h09: rom_word = `ROM_09;
            5'h0A: rom_word = `ROM_0A;
            5'h0B, 5'h0C, 5'h0D, 5'h0E: rom_word = `ROM_0B;
            5'h0F: rom_word = `ROM_0F;
            5'h10: rom_word = `ROM_10;
            5'h11: rom_word = `ROM_11;
            5'h12: rom_word = `ROM_12;
            5'h13: rom_word = `ROM_13;
            5'h14: rom_word = `ROM_14;
            default: rom_word = `BLANK_WORD;
        endcase
    endfunction

    function automatic logic [15:0] pick(input logic rom, input logic [15:0] ee, input logic [4:0] a);
        pick = rom ? rom_word(a) : ee;
    endfunction

    // Loader: sequential word reads, checksum, decode, power-down writes
    always_comb
    begin
        logic [15:0] fl;
        logic [15:0] m0;
        logic [15:0] m1;
        logic [15:0] m2;
        logic [15:0] po;
        logic [15:0] mp;
        logic [15:0] id;
        logic [15:0] wm;
        fl = pick(use_rom_r, img_r[`W_FLAG], `W_FLAG);
        m0 = pick(use_rom_r, img_r[`W_MAC0], `W_MAC0);
        m1 = pick(use_rom_r, img_r[`W_MAC1], `W_MAC1);
        m2 = pick(use_rom_r, img_r[`W_MAC2], `W_MAC2);
        po = pick(use_rom_r, img_r[`W_PHYOFS], `W_PHYOFS);
        mp = pick(use_rom_r, img_r[`W_MAXPKT], `W_MAXPKT);
        id = pick(use_rom_r, img_r[`W_PHYID], `W_PHYID);
        wm = pick(use_rom_r, img_r[`W_WATER], `W_WATER);
        state_nxt = state_r;
        img_we = 1'b0;
        mem_addr_nxt = mem_addr_r;
        mem_rd_nxt = 1'b0;
        sum_nxt = sum_r;
        csum_nxt = csum_r;
        use_rom_nxt = use_rom_r;
        blank_nxt = blank_r;
        done_nxt = config_done_r;
        cfg_nxt = cfg_r;
        mgmt_idx_nxt = mgmt_idx_r;
        mgmt_req_nxt = mgmt_req_r;
        mgmt_cmd_nxt = mgmt_cmd_r;
        mgmt_done_nxt = mgmt_done_r;
        case (state_r)
            LD_IDLE:
            begin
                mem_addr_nxt = `W_COUNT;
                mem_rd_nxt = 1'b1;
                state_nxt = LD_WAIT;
            end
            LD_WAIT:
            begin
                if (mem_valid)
                begin
                    img_we = (mem_addr_r <= `W_LAST_PRELOAD);
                    if (mem_addr_r >= `W_SUM_FIRST && mem_addr_r <= `W_SUM_LAST)
                    begin
                        sum_nxt = sum_r + mem_data[7:0] + mem_data[15:8];
                    end
                    if (mem_addr_r == `W_CHECKSUM)
                    begin
                        csum_nxt = mem_data[7:0];
                        state_nxt = LD_CHECK;
                    end
                    else
                    begin
                        // Reserved words 15h..17h are skipped
                        mem_addr_nxt = (mem_addr_r == `W_LAST_PRELOAD) ? `W_CHECKSUM : mem_addr_r + 5'h01;
                        mem_rd_nxt = 1'b1;
                    end
                end
            end
            LD_CHECK:
            begin
                blank_nxt = (img_r[`W_COUNT] == `BLANK_WORD);
                use_rom_nxt = blank_nxt || ((`SUM_BASE - sum_r) != csum_r);
                state_nxt = LD_APPLY;
            end
            LD_APPLY:
            begin
                cfg_nxt.self_powered_flag = fl[`F_SELF_PWR];
                cfg_nxt.ref_clock_drive_out = fl[`F_REF_OUT];
                cfg_nxt.remote_wake_capable = fl[`F_RWAKE];
                cfg_nxt.phy_copper_fiber_select = fl[`F_COPPER];
                cfg_nxt.rx_strip_fcs = fl[`F_STRIP];
                cfg_nxt.tx_append_fcs = fl[`F_APPEND];
                cfg_nxt.capture_effect_enable = fl[`F_CAPTURE];
                cfg_nxt.test_port_enable = fl[`F_TEST];
                cfg_nxt.rmii_isolate = fl[`F_ISOLATE];
                cfg_nxt.wake_pin_select = fl[`F_WPIN];
                cfg_nxt.wake_out_polarity = fl[`F_WPOL];
                cfg_nxt.wake_out_drive_type = fl[`F_WTYPE];
                cfg_nxt.wake_out_pulse_mode = fl[`F_WPULSE];
                cfg_nxt.station_address = {m0[7:0], m0[15:8], m1[7:0], m1[15:8], m2[7:0], m2[15:8]};
                cfg_nxt.phy_reg_offset1 = po[12:8];
                cfg_nxt.phy_reg_offset2 = po[4:0];
                cfg_nxt.embedded_phy_link_mode = po[15:13];
                cfg_nxt.max_frame_size = mp[10:0];
                cfg_nxt.primary_phy_kind_code = id[7:5];
                cfg_nxt.primary_phy_mgmt_address = id[4:0];
                cfg_nxt.secondary_phy_kind_code = id[15:13];
                cfg_nxt.secondary_phy_mgmt_address = id[12:8];
                cfg_nxt.primary_phy_supported = (id[7:5] != `KIND_UNSUPPORTED);
                cfg_nxt.secondary_phy_supported = (id[15:13] != `KIND_UNSUPPORTED);
                cfg_nxt.pause_high_mark = wm[15:8];
                cfg_nxt.pause_low_mark = wm[7:0];
                done_nxt = 1'b1;
                if (mac_mode_ext_rmii && !wol_ready_mode)
                begin
                    mgmt_idx_nxt = 2'h0;
                    mgmt_req_nxt = 1'b1;
                    mgmt_cmd_nxt.phy_addr = `MGMT_BROADCAST;
                    mgmt_cmd_nxt.reg_addr = `MGMT_CTRL_REG;
                    mgmt_cmd_nxt.data = `MGMT_PWR_DOWN;
                    state_nxt = LD_MGMT;
                end
                else
                begin
                    state_nxt = LD_DONE;
                end
            end
            LD_MGMT:
            begin
                if (mgmt_ack)
                begin
                    if (mgmt_idx_r == `MGMT_LAST_IDX)
                    begin
                        mgmt_req_nxt = 1'b0;
                        mgmt_done_nxt = 1'b1;
                        state_nxt = LD_DONE;
                    end
                    else
                    begin
                        // Primary then secondary, in that order
                        mgmt_idx_nxt = mgmt_idx_r + 2'h1;
                        mgmt_cmd_nxt.phy_addr = (mgmt_idx_r == 2'h0) ? cfg_r.primary_phy_mgmt_address
                                                                      : cfg_r.secondary_phy_mgmt_address;
                    end
                end
            end
            LD_DONE:
            begin
                state_nxt = LD_DONE;
            end
            default:
            begin
                state_nxt = LD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_r <= LD_IDLE;
            mem_addr_r <= `W_COUNT;
            mem_rd_r <= 1'b0;
            sum_r <= 8'h00;
            csum_r <= 8'h00;
            use_rom_r <= 1'b0;
            blank_r <= 1'b0;
            config_done_r <= 1'b0;
            cfg_r <= '0;
            mgmt_idx_r <= 2'h0;
            mgmt_req_r <= 1'b0;
            mgmt_cmd_r <= '0;
            mgmt_done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            mem_addr_r <= mem_addr_nxt;
            mem_rd_r <= mem_rd_nxt;
            sum_r <= sum_nxt;
            csum_r <= csum_nxt;
            use_rom_r <= use_rom_nxt;
            blank_r <= blank_nxt;
            config_done_r <= done_nxt;
            cfg_r <= cfg_nxt;
            mgmt_idx_r <= mgmt_idx_nxt;
            mgmt_req_r <= mgmt_req_nxt;
            mgmt_cmd_r <= mgmt_cmd_nxt;
            mgmt_done_r <= mgmt_done_nxt;
        end
    end

    // Image storage has no reset; the loader reads it only after every word has landed
    always_ff @(posedge clk)
    begin
        if (img_we)
        begin
            img_r[mem_addr_r] <= mem_data;
        end
    end

    // Embedded PHY mode capture, wake output, flow control, pins, register port
    logic phy_run_r, phy_run_nxt;
    logic [2:0] link_mode_nxt;
    logic wake_act_r, wake_act_nxt;
    logic [16:0] wake_cnt_r, wake_cnt_nxt;
    logic wake_out_nxt, wake_oe_nxt;
    logic gpio_val_r, gpio_val_nxt;
    logic flow_r, flow_nxt;
    logic pause_nxt, jam_nxt, rx_oe_nxt, ref_oe_nxt;
    logic [31:0] rdata_nxt;

    always_comb
    begin
        logic level;
        logic clr;
        clr = reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_WAKE_CLR];
        gpio_val_nxt = (reg_wr && reg_addr == `REG_CTRL) ? reg_wdata[`CTRL_GPIO_VAL] : gpio_val_r;
        // Capture on the first cycle the PHY is out of reset after the preload is done, stored image or fallback
        phy_run_nxt = phy_reset_n && config_done_r;
        link_mode_nxt = (phy_run_nxt && !phy_run_r) ? cfg_r.embedded_phy_link_mode
                                                    : embedded_phy_link_mode_r;
        wake_act_nxt = wake_act_r;
        wake_cnt_nxt = wake_cnt_r;
        if (wake_act_r && cfg_r.wake_out_pulse_mode)
        begin
            wake_cnt_nxt = wake_cnt_r - 17'h00001;
            if (wake_cnt_r == 17'h00001)
            begin
                wake_act_nxt = 1'b0;
            end
        end
        else if (clr)
        begin
            wake_act_nxt = 1'b0;
        end
        // A new event beats a software clear in the same cycle
        if (wake_event && config_done_r)
        begin
            wake_act_nxt = 1'b1;
            wake_cnt_nxt = PULSE_LEN;
        end
        level = wake_act_r ? cfg_r.wake_out_polarity : ~cfg_r.wake_out_polarity;
        if (!cfg_r.wake_pin_select)
        begin
            level = gpio_val_r;
        end
        // Open-drain only pulls low, so a high level means release
        wake_out_nxt = cfg_r.wake_out_drive_type ? level : 1'b0;
        wake_oe_nxt = config_done_r && (cfg_r.wake_out_drive_type || !level);
        flow_nxt = flow_r;
        if (!config_done_r)
        begin
            flow_nxt = 1'b0;
        end
        else if (free_buffers <= cfg_r.pause_high_mark)
        begin
            flow_nxt = 1'b1;
        end
        else if (free_buffers >= cfg_r.pause_low_mark)
        begin
            flow_nxt = 1'b0;
        end
        pause_nxt = flow_r && full_duplex;
        jam_nxt = flow_r && !full_duplex;
        rx_oe_nxt = config_done_r && phy_mode && !cfg_r.rmii_isolate;
        ref_oe_nxt = config_done_r && cfg_r.ref_clock_drive_out;
        rdata_nxt = 32'h00000000;
        if (reg_rd)
        begin
            case (reg_addr)
                `REG_STATUS: rdata_nxt = {26'h0000000, wake_act_r, flow_r, mgmt_done_r, blank_r,
                                          use_rom_r, config_done_r};
                `REG_FLAG: rdata_nxt = {16'h0000, pick(use_rom_r, img_r[`W_FLAG], `W_FLAG)};
                `REG_CTRL: rdata_nxt = {30'h00000000, gpio_val_r, 1'b0};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            phy_run_r <= 1'b0;
            embedded_phy_link_mode_r <= 3'h0;
            wake_act_r <= 1'b0;
            wake_cnt_r <= 17'h00000;
            wake_pin_out_r <= 1'b0;
            wake_pin_oe_r <= 1'b0;
            gpio_val_r <= 1'b0;
            flow_r <= 1'b0;
            pause_active_r <= 1'b0;
            jam_active_r <= 1'b0;
            rmii_rx_oe_r <= 1'b0;
            rmii_ref_oe_r <= 1'b0;
            reg_rdata_r <= 32'h00000000;
        end
        else
        begin
            phy_run_r <= phy_run_nxt;
            embedded_phy_link_mode_r <= link_mode_nxt;
            wake_act_r <= wake_act_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            wake_pin_out_r <= wake_out_nxt;
            wake_pin_oe_r <= wake_oe_nxt;
            gpio_val_r <= gpio_val_nxt;
            flow_r <= flow_nxt;
            pause_active_r <= pause_nxt;
            jam_active_r <= jam_nxt;
            rmii_rx_oe_r <= rx_oe_nxt;
            rmii_ref_oe_r <= ref_oe_nxt;
            reg_rdata_r <= rdata_nxt;
        end
    end

endmodule // eeprom_config_preload

// *** tb/eeprom_config_props.sv ***
`timescale 1ns/100ps
module eeprom_config_props
    import eeprom_config_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Memory and modes
    input wire logic mem_rd_r,
    input wire logic [4:0] mem_addr_r,
    input wire logic mem_valid,
    input wire logic mac_mode_ext_rmii,
    input wire logic wol_ready_mode,
    input wire logic phy_reset_n,
    // Management and config
    input wire logic mgmt_req_r,
    input wire mgmt_req_type mgmt_cmd_r,
    input wire logic mgmt_ack,
    input wire logic config_done_r,
    input wire cfg_type cfg_r,
    input wire logic [2:0] embedded_phy_link_mode_r,
    // Flow control
    input wire logic [7:0] free_buffers,
    input wire logic full_duplex,
    input wire logic pause_active_r,
    input wire logic jam_active_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic seen_r, seen_nxt;
    logic [4:0] last_r, last_nxt;
    always_comb
    begin
        seen_nxt = (seen_r | mem_rd_r) & reset_n;
        last_nxt = mem_rd_r ? mem_addr_r : last_r;
    end
    always_ff @(posedge clk)
    begin
        seen_r <= seen_nxt;
        last_r <= last_nxt;
    end
    sequence s_last_word;
        mem_valid && mem_addr_r == 5'h18;
    endsequence
    sequence s_crowd(logic dup);
        config_done_r && full_duplex == dup && free_buffers <= cfg_r.pause_high_mark;
    endsequence
    a_addr_order: assert property (mem_rd_r |-> mem_addr_r ==
        (!seen_r ? 5'h00 : (last_r == 5'h14 ? 5'h18 : last_r + 5'h01))) else $error("read address out of order");
    a_read_next: assert property (mem_valid && mem_addr_r != 5'h18 |=> mem_rd_r)
        else $error("no read after word arrived");
    a_read_single: assert property (mem_rd_r |=> !mem_rd_r)
        else $error("read strobe longer than one cycle");
    a_load_ends: assert property (s_last_word |-> ##[1:4] config_done_r)
        else $error("preload did not complete");
    a_cfg_held: assert property (!config_done_r |-> cfg_r == '0 && !mgmt_req_r)
        else $error("config released before preload");
    a_mgmt_gate: assert property ($rose(mgmt_req_r) |-> mac_mode_ext_rmii && !wol_ready_mode
        && mgmt_cmd_r.phy_addr == 5'h00 && mgmt_cmd_r.reg_addr == 5'h00) else $error("bad power-down start");
    a_mgmt_hold: assert property (mgmt_req_r && !mgmt_ack |=> mgmt_req_r && $stable(mgmt_cmd_r))
        else $error("management request dropped");
    a_mgmt_step: assert property (mgmt_req_r && mgmt_ack && mgmt_cmd_r.phy_addr == 5'h00
        |=> mgmt_cmd_r.phy_addr == cfg_r.primary_phy_mgmt_address) else $error("primary not second");
    a_pause_on: assert property (s_crowd(1'b1) ##1 s_crowd(1'b1) |=> pause_active_r)
        else $error("pause not started");
    a_jam_on: assert property (s_crowd(1'b0) ##1 s_crowd(1'b0) |=> jam_active_r)
        else $error("jam not started");
    a_mode_latch: assert property (config_done_r && phy_reset_n && !$past(config_done_r && phy_reset_n)
        |=> embedded_phy_link_mode_r == cfg_r.embedded_phy_link_mode) else $error("mode not latched");
endmodule // eeprom_config_props

// *** tb/eeprom_model.sv ***
`timescale 1ns/100ps
module eeprom_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Word port
    input wire logic mem_rd_r,
    input wire logic [4:0] mem_addr_r,
    input wire logic [1:0] lat,
    output logic mem_valid,
    output logic [15:0] mem_data
);
    logic [15:0] mem [32];
    logic [4:0] addr_r;
    logic [1:0] cnt_r;
    always_ff @(posedge clk)
    begin
        mem_valid <= 1'b0;
        // Stale data flips so a late sample never looks right
        mem_data <= ~mem_data;
        if (!reset_n)
        begin
            cnt_r <= 2'h0;
            mem_data <= 16'h0000;
        end
        else if (mem_rd_r)
        begin
            addr_r <= mem_addr_r;
            cnt_r <= lat;
        end
        else if (cnt_r != 2'h0)
        begin
            cnt_r <= cnt_r - 2'h1;
            if (cnt_r == 2'h1)
            begin
                mem_valid <= 1'b1;
                mem_data <= mem[addr_r];
            end
        end
    end
endmodule // eeprom_model

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
    import eeprom_config_pkg::*;
;
    logic clk, reset_n, mem_rd_r, mem_valid, mac_mode_ext_rmii, phy_mode, wol_ready_mode, phy_reset_n;
    logic mgmt_req_r, mgmt_ack, config_done_r, full_duplex, pause_active_r, jam_active_r, wake_event;
    logic wake_pin_out_r, wake_pin_oe_r, rmii_rx_oe_r, rmii_ref_oe_r, reg_wr, reg_rd;
    logic [4:0] mem_addr_r;
    logic [15:0] mem_data;
    logic [1:0] lat;
    logic [2:0] embedded_phy_link_mode_r;
    logic [7:0] free_buffers;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_r, rv;
    mgmt_req_type mgmt_cmd_r;
    cfg_type cfg_r;
    int num_errors, check_count, cnt;
    // Checksum FCh covers the single 0102h word in 07h..0Eh
    logic [15:0] img [25] = '{16'h5A15, 16'hF54F, 16'h0, 16'h0, 16'h2301, 16'h6745, 16'hAB89, 16'h0102,
        16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hA386, 16'h05EE, 16'hE503, 16'h2040,
        16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h00FC};
    eeprom_config_preload #(.WAKE_PULSE_CYCLES(8)) dut (.clk, .reset_n, .mem_rd_r, .mem_addr_r, .mem_valid,
        .mem_data, .mac_mode_ext_rmii, .phy_mode, .wol_ready_mode, .phy_reset_n, .mgmt_req_r, .mgmt_cmd_r,
        .mgmt_ack, .config_done_r, .cfg_r, .embedded_phy_link_mode_r, .free_buffers, .full_duplex,
        .pause_active_r, .jam_active_r, .wake_event, .wake_pin_out_r, .wake_pin_oe_r, .rmii_rx_oe_r,
        .rmii_ref_oe_r, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r);
    eeprom_model eep (.clk, .reset_n, .mem_rd_r, .mem_addr_r, .lat, .mem_valid, .mem_data);
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [12:0] flags_of(input logic [15:0] w);
        return {w[0], w[1], w[2], w[5], w[6], w[7], w[8], w[9], w[11], w[12], w[13], w[14], w[15]};
    endfunction
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick();
        reg_rd <= 1'b0;
        rv = reg_rdata_r;
        // One idle edge so a following call never drives a strobe twice in one step
        tick();
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick();
        reg_wr <= 1'b0;
        tick();
    endtask
    task automatic run(input int kind);
        for (int i = 0; i < 32; i++)
            eep.mem[i] = (kind == 2) ? 16'hFFFF : ((i < 25) ? img[i] : 16'h0000);
        if (kind == 1)
            eep.mem[24] = 16'h00FB;
        reset_n <= 1'b0;
        phy_reset_n <= 1'b0;
        repeat (8) tick();
        reset_n <= 1'b1;
        for (cnt = 0; cnt < 3000 && config_done_r !== 1'b1; cnt++)
            tick();
        if (cnt == 3000)
        begin
            check(config_done_r, 1'b1);
            stop_test();
        end
    endtask
    initial
    begin
        {mgmt_ack, full_duplex, wake_event, reg_wr, reg_rd, wol_ready_mode} = '0;
        {reg_addr, reg_wdata} = '0;
        {mac_mode_ext_rmii, phy_mode} = 2'b11;
        free_buffers = 8'hFF;
        lat = 2'h1;
        run(0);
        check(cfg_r[$bits(cfg_type)-1 -: 13], flags_of(16'hF54F));
        check(cfg_r.station_address, 48'h0123456789AB);
        check({cfg_r.phy_reg_offset1, cfg_r.phy_reg_offset2, cfg_r.max_frame_size}, {10'h066, 11'h5EE});
        check({cfg_r[33:18], cfg_r.primary_phy_supported, cfg_r.secondary_phy_supported}, {16'h03E5, 2'b10});
        foreach (img[i])
            if (i < 3)
            begin
                check({mgmt_req_r, mgmt_cmd_r}, {1'b1, (i == 0 ? 5'h00 : (i == 1 ? img[17][4:0] : img[17][12:8])),
                    5'h00, 16'h0800});
                mgmt_ack <= 1'b1;
                tick();
                mgmt_ack <= 1'b0;
                tick();
            end
        check(mgmt_req_r, 1'b0);
        // Pin enables follow the done flag one edge later, so look only now
        check({cfg_r.pause_high_mark, cfg_r.pause_low_mark, rmii_rx_oe_r, rmii_ref_oe_r}, 18'h08103);
        phy_reset_n <= 1'b1;
        repeat (3) tick();
        check(embedded_phy_link_mode_r, 3'b101);
        rd(4'h0);
        check(rv[3:0], 4'h9);
        rd(4'h4);
        check(rv, 32'h0000F54F);
        rd(4'hC);
        check(rv, 32'h0);
        wake_event <= 1'b1;
        tick();
        wake_event <= 1'b0;
        cnt = 0;
        repeat (20)
        begin
            tick();
            cnt += (wake_pin_out_r === 1'b1);
        end
        check({cnt, wake_pin_oe_r}, {32'd8, 1'b1});
        full_duplex <= 1'b1;
        free_buffers <= 8'h20;
        repeat (4) tick();
        check({pause_active_r, jam_active_r}, 2'b10);
        free_buffers <= 8'h40;
        repeat (4) tick();
        check({pause_active_r, jam_active_r}, 2'b00);
        full_duplex <= 1'b0;
        free_buffers <= 8'h10;
        repeat (4) tick();
        check({pause_active_r, jam_active_r}, 2'b01);
        free_buffers <= 8'hFF;
        wol_ready_mode <= 1'b1;
        lat = 2'h3;
        run(1);
        check({cfg_r[$bits(cfg_type)-1 -: 13], cfg_r.station_address}, {flags_of(16'h1DFD), 48'h0});
        rd(4'h0);
        check({rv[2:0], mgmt_req_r, wake_pin_oe_r}, 5'b01100);
        wake_event <= 1'b1;
        tick();
        wake_event <= 1'b0;
        repeat (12) tick();
        check({wake_pin_out_r, wake_pin_oe_r}, 2'b01);
        wr(4'h8, 32'h1);
        repeat (3) tick();
        check(wake_pin_oe_r, 1'b0);
        mac_mode_ext_rmii <= 1'b0;
        wol_ready_mode <= 1'b0;
        lat = 2'h2;
        run(2);
        rd(4'h0);
        check({rv[2:0], mgmt_req_r, rmii_rx_oe_r, rmii_ref_oe_r}, 6'b111000);
        check({cfg_r.phy_reg_offset1, cfg_r.phy_reg_offset2, cfg_r.max_frame_size}, {10'h0A0, 11'h600});
        check({cfg_r[33:18], cfg_r.pause_high_mark, cfg_r.pause_low_mark}, 32'h10E02442);
        stop_test();
    end
endmodule // tb_top
bind eeprom_config_preload eeprom_config_props props (.clk, .reset_n, .mem_rd_r, .mem_addr_r, .mem_valid,
    .mac_mode_ext_rmii, .wol_ready_mode, .phy_reset_n, .mgmt_req_r, .mgmt_cmd_r, .mgmt_ack, .config_done_r,
    .cfg_r, .embedded_phy_link_mode_r, .free_buffers, .full_duplex, .pause_active_r, .jam_active_r);
